// >>> hw/ssc_top.sv
// serial port with control, fifo data and status registers and a frame shifter
`timescale 1ns/100ps
`default_nettype none
`include "ssc_cfg.svh"
module ssc_top
    import ssc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [`SSC_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq,
    output logic link_clk_out,
    output logic link_clk_oe_b,
    input wire logic link_clk_in,
    output logic sel_out_b,
    output logic sel_oe_b,
    input wire logic sel_in_b,
    output logic serial_data_out,
    output logic serial_data_out_oe_b,
    input wire logic serial_data_in
);
    localparam int DEPTH = `SSC_FIFO_DEPTH;
    localparam logic [4:0] HALF = 5'(`SSC_HALF_CYC);

    ssc_ctrl_type ctrl_r; // second control register
    logic [3:0] size_r; // frame_size_select field
    logic [2:0] irq_stat_r; // sticky event bits
    logic [2:0] irq_mask_r; // event enables
    ssc_stat_type stat; // live status view
    ssc_state_type state_r; // shifter state
    logic [15:0] tx_mem [DEPTH]; // transmit fifo storage
    logic [15:0] rx_mem [DEPTH]; // receive fifo storage
    logic [2:0] tx_wp_r, tx_rp_r, rx_wp_r, rx_rp_r; // fifo pointers
    logic [3:0] tx_cnt_r, rx_cnt_r; // fifo fill levels
    logic [15:0] tx_sh_r, rx_sh_r; // transmit and receive shifters
    logic [4:0] bit_cnt_r; // bits shifted in this frame
    logic [4:0] div_r; // master half-period counter
    logic mclk_r; // master serial clock level
    logic msel_r; // master select asserted
    logic [2:0] sclk_sync_r, sel_sync_r; // slave pin synchronisers plus edge stage
    logic [1:0] sdi_sync_r; // data input synchroniser
    logic [4:0] frame_len; // frame length in bits
    logic [3:0] sh_amt; // left shift that aligns frame msb to bit 15
    logic wr_data, rd_data; // data register accesses
    logic tx_push, tx_pop, rx_push, rx_pop; // fifo moves
    logic is_master, is_slave; // active role
    logic start_ev, sample_ev, shift_ev, last_ev, abort_ev; // shifter events
    logic in_bit; // bit entering the receive shifter
    logic [2:0] irq_set; // event pulses

    // frame length from size field, reserved codes held at four bits
    always_comb begin
        if (size_r < `SSC_MIN_SIZE) begin
            frame_len = 5'd4;
        end else begin
            frame_len = {1'b0, size_r} + 5'd1;
        end
        sh_amt = 4'(5'd16 - frame_len);
    end

    assign is_master = ctrl_r.en && !ctrl_r.role;
    assign is_slave = ctrl_r.en && ctrl_r.role;
    assign wr_data = reg_wr && (reg_addr == `SSC_OFS_FIFO_DATA);
    assign rd_data = reg_rd && (reg_addr == `SSC_OFS_FIFO_DATA);
    assign tx_push = wr_data && (tx_cnt_r != 4'(DEPTH));
    assign rx_pop = rd_data && (rx_cnt_r != 4'd0);

    // status view, reset leaves counts zero so idle and empty
    always_comb begin
        stat.busy = (state_r != SSC_ST_IDLE) || (tx_cnt_r != 4'd0);
        stat.rx_fifo_full = (rx_cnt_r == 4'(DEPTH));
        stat.rx_fifo_not_empty = (rx_cnt_r != 4'd0);
        stat.tx_fifo_not_full = (tx_cnt_r != 4'(DEPTH));
        stat.tx_fifo_empty = (tx_cnt_r == 4'd0);
    end

    // slave pins pass two flops, third stage only for edge finding
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            sclk_sync_r <= 3'h0;
            sel_sync_r <= 3'h7;
            sdi_sync_r <= 2'h0;
        end else begin
            sclk_sync_r <= {sclk_sync_r[1:0], link_clk_in};
            sel_sync_r <= {sel_sync_r[1:0], sel_in_b};
            sdi_sync_r <= {sdi_sync_r[0], serial_data_in};
        end
    end

    // receive input, internal loop when loopback is on
    always_comb begin
        if (ctrl_r.lb) begin
            in_bit = tx_sh_r[15];
        end else begin
            in_bit = sdi_sync_r[1];
        end
    end

    // shifter events for both roles, mode 0 timing
    always_comb begin
        start_ev = 1'b0;
        sample_ev = 1'b0;
        shift_ev = 1'b0;
        abort_ev = 1'b0;
        if (is_master) begin
            // master starts once data waits and runs its own divider
            start_ev = (state_r == SSC_ST_IDLE) && (tx_cnt_r != 4'd0);
            sample_ev = (state_r == SSC_ST_SHIFT) && !mclk_r && (div_r == HALF - 5'd1);
            shift_ev = (state_r == SSC_ST_SHIFT) && mclk_r && (div_r == HALF - 5'd1);
        end else if (is_slave) begin
            // slave follows the peer's select and clock edges
            start_ev = (state_r == SSC_ST_IDLE) && sel_sync_r[2] && !sel_sync_r[1];
            sample_ev = (state_r == SSC_ST_SHIFT) && !sclk_sync_r[2] && sclk_sync_r[1];
            shift_ev = (state_r == SSC_ST_SHIFT) && sclk_sync_r[2] && !sclk_sync_r[1];
            abort_ev = (state_r == SSC_ST_SHIFT) && sel_sync_r[1];
        end else begin
            abort_ev = (state_r == SSC_ST_SHIFT); // port disabled mid-frame
        end
        last_ev = shift_ev && (bit_cnt_r == frame_len - 5'd1);
    end

    // a new word is taken at frame start, or back to back for a held slave select
    assign tx_pop = (start_ev || (last_ev && is_slave && !abort_ev)) && (tx_cnt_r != 4'd0);
    assign rx_push = last_ev && !abort_ev && (rx_cnt_r != 4'(DEPTH));

    // shifter state machine
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            state_r <= SSC_ST_IDLE;
        end else begin
            unique case (state_r)
                SSC_ST_IDLE: begin
                    if (start_ev) begin
                        state_r <= SSC_ST_SHIFT;
                    end
                end
                SSC_ST_SHIFT: begin
                    // master always rests a frame apart, slave stays while selected
                    if (abort_ev || (last_ev && is_master)) begin
                        state_r <= SSC_ST_IDLE;
                    end
                end
            endcase
        end
    end

    // transmit shifter, frame msb aligned to bit 15 so upper bits drop out
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            tx_sh_r <= 16'h0000;
        end else if (start_ev || last_ev) begin
            if (tx_pop) begin
                tx_sh_r <= tx_mem[tx_rp_r] << sh_amt;
            end else begin
                tx_sh_r <= 16'h0000;
            end
        end else if (shift_ev) begin
            tx_sh_r <= {tx_sh_r[14:0], 1'b0};
        end
    end

    // receive shifter, cleared per frame so the word lands at the lsb end
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            rx_sh_r <= 16'h0000;
        end else if (start_ev || last_ev) begin
            rx_sh_r <= 16'h0000;
        end else if (sample_ev) begin
            rx_sh_r <= {rx_sh_r[14:0], in_bit};
        end
    end

    // bit counter
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            bit_cnt_r <= 5'd0;
        end else if (start_ev || last_ev || abort_ev) begin
            bit_cnt_r <= 5'd0;
        end else if (shift_ev) begin
            bit_cnt_r <= bit_cnt_r + 5'd1;
        end
    end

    // master clock divider and select
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            div_r <= 5'd0;
            mclk_r <= 1'b0;
            msel_r <= 1'b0;
        end else if (state_r == SSC_ST_SHIFT && is_master && !last_ev) begin
            msel_r <= 1'b1;
            if (div_r == HALF - 5'd1) begin
                div_r <= 5'd0;
                mclk_r <= !mclk_r;
            end else begin
                div_r <= div_r + 5'd1;
            end
        end else begin
            div_r <= 5'd0;
            mclk_r <= 1'b0;
            msel_r <= start_ev && is_master;
        end
    end

    // transmit fifo
    always_ff @(posedge core_clk) begin
        if (tx_push) begin
            tx_mem[tx_wp_r] <= reg_wdata[15:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            tx_wp_r <= 3'd0;
            tx_rp_r <= 3'd0;
            tx_cnt_r <= 4'd0;
        end else begin
            if (tx_push) begin
                tx_wp_r <= tx_wp_r + 3'd1;
            end
            if (tx_pop) begin
                tx_rp_r <= tx_rp_r + 3'd1;
            end
            tx_cnt_r <= tx_cnt_r + 4'(tx_push) - 4'(tx_pop);
        end
    end

    // receive fifo, a frame arriving while full is dropped
    always_ff @(posedge core_clk) begin
        if (rx_push) begin
            rx_mem[rx_wp_r] <= rx_sh_r;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            rx_wp_r <= 3'd0;
            rx_rp_r <= 3'd0;
            rx_cnt_r <= 4'd0;
        end else begin
            if (rx_push) begin
                rx_wp_r <= rx_wp_r + 3'd1;
            end
            if (rx_pop) begin
                rx_rp_r <= rx_rp_r + 3'd1;
            end
            rx_cnt_r <= rx_cnt_r + 4'(rx_push) - 4'(rx_pop);
        end
    end

    // control and configuration writes
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            ctrl_r <= '0;
            size_r <= `SSC_RST_SIZE;
        end else if (reg_wr) begin
            if (reg_addr == `SSC_OFS_CTRL_TWO) begin
                ctrl_r.slave_output_disable <= reg_wdata[`SSC_BIT_OUT_OFF];
                ctrl_r.role <= reg_wdata[`SSC_BIT_ROLE];
                ctrl_r.en <= reg_wdata[`SSC_BIT_EN];
                ctrl_r.lb <= reg_wdata[`SSC_BIT_LB];
            end else if (reg_addr == `SSC_OFS_FRAME_CFG) begin
                size_r <= reg_wdata[3:0];
            end
        end
    end

    // event pulses
    assign irq_set[`SSC_IRQ_RX_DONE] = rx_push;
    assign irq_set[`SSC_IRQ_RX_OVR] = last_ev && !abort_ev && stat.rx_fifo_full;
    assign irq_set[`SSC_IRQ_TX_EMPTY] = tx_pop && (tx_cnt_r == 4'd1) && !tx_push;

    // sticky events, a new event wins over a write-one clear
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            irq_stat_r <= 3'h0;
            irq_mask_r <= 3'h0;
        end else begin
            if (reg_wr && reg_addr == `SSC_OFS_IRQ_STATUS) begin
                irq_stat_r <= (irq_stat_r & ~reg_wdata[2:0]) | irq_set;
            end else begin
                irq_stat_r <= irq_stat_r | irq_set;
            end
            if (reg_wr && reg_addr == `SSC_OFS_IRQ_MASK) begin
                irq_mask_r <= reg_wdata[2:0];
            end
        end
    end

    assign irq = |(irq_stat_r & irq_mask_r);

    // read data stands the cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `SSC_OFS_FRAME_CFG: reg_rdata <= {28'h0, size_r};
                `SSC_OFS_CTRL_TWO: reg_rdata <= {28'h0, ctrl_r};
                `SSC_OFS_FIFO_DATA: begin
                    // empty fifo reads zero and pops nothing
                    reg_rdata <= rx_pop ? {16'h0, rx_mem[rx_rp_r]} : 32'h0;
                end
                `SSC_OFS_FIFO_STATUS: reg_rdata <= {27'h0, stat};
                `SSC_OFS_IRQ_STATUS: reg_rdata <= {29'h0, irq_stat_r};
                `SSC_OFS_IRQ_MASK: reg_rdata <= {29'h0, irq_mask_r};
                default: reg_rdata <= 32'h0; // unmapped reads zero
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // pins: master drives clock and select, slave drives data while selected unless disabled
    always_comb begin
        link_clk_out = mclk_r;
        link_clk_oe_b = !is_master;
        sel_out_b = !msel_r;
        sel_oe_b = !is_master;
        serial_data_out = tx_sh_r[15];
        if (is_master) begin
            serial_data_out_oe_b = 1'b0;
        end else begin
            serial_data_out_oe_b = !(is_slave && !ctrl_r.slave_output_disable
                && !sel_sync_r[1]);
        end
    end
endmodule
`default_nettype wire

// >>> hw/ssc_cfg.svh
// register map, field positions, reset values and timing counts of the serial port
`ifndef SSC_CFG_SVH
`define SSC_CFG_SVH
`define SSC_ADDR_W 8
`define SSC_OFS_FRAME_CFG 8'h00
`define SSC_OFS_CTRL_TWO 8'h04
`define SSC_OFS_FIFO_DATA 8'h08
`define SSC_OFS_FIFO_STATUS 8'h0c
`define SSC_OFS_IRQ_STATUS 8'h10
`define SSC_OFS_IRQ_MASK 8'h14
`define SSC_BIT_OUT_OFF 3
`define SSC_BIT_ROLE 2
`define SSC_BIT_EN 1
`define SSC_BIT_LB 0
`define SSC_BIT_BUSY 4
`define SSC_BIT_RX_FULL 3
`define SSC_BIT_RX_AVAIL 2
`define SSC_BIT_TX_ROOM 1
`define SSC_BIT_TX_VOID 0
`define SSC_IRQ_RX_DONE 0
`define SSC_IRQ_RX_OVR 1
`define SSC_IRQ_TX_EMPTY 2
`define SSC_RST_SIZE 4'h0
`define SSC_MIN_SIZE 4'h3
`define SSC_FIFO_DEPTH 8
`define SSC_CLK_PERIOD_NS 8
`define SSC_LINK_PERIOD_NS 125
`define SSC_HALF_CYC ((`SSC_LINK_PERIOD_NS / 2 + `SSC_CLK_PERIOD_NS - 1) / `SSC_CLK_PERIOD_NS)
`endif

// >>> hw/ssc_pkg.sv
// types shared by the serial port block
`default_nettype none
package ssc_pkg;
    // fields of the second control register
    typedef struct packed {
        logic slave_output_disable;
        logic role;
        logic en;
        logic lb;
    } ssc_ctrl_type;
    // fields of the fifo status register
    typedef struct packed {
        logic busy;
        logic rx_fifo_full;
        logic rx_fifo_not_empty;
        logic tx_fifo_not_full;
        logic tx_fifo_empty;
    } ssc_stat_type;
    typedef enum logic {SSC_ST_IDLE, SSC_ST_SHIFT} ssc_state_type;
endpackage
`default_nettype wire

// >>> tb/ssc_top_sva.sv
// checker of the serial port pins and register answers
`timescale 1ns/100ps
`default_nettype none
`include "ssc_cfg.svh"
module ssc_top_chk (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [`SSC_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic irq,
    input wire logic link_clk_out,
    input wire logic link_clk_oe_b,
    input wire logic sel_out_b,
    input wire logic sel_oe_b,
    input wire logic serial_data_out_oe_b
);
    logic [3:0] ctl_r, ctl_d_r, ctl_e_r; // shadow of control two and two delayed copies
    logic calm; // control unchanged for three cycles
    // shadow control writes
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            ctl_r <= 4'h0;
        end else if (reg_wr && reg_addr == `SSC_OFS_CTRL_TWO) begin
            ctl_r <= reg_wdata[3:0];
        end
        ctl_d_r <= ctl_r;
        ctl_e_r <= ctl_d_r;
    end
    assign calm = (ctl_r == ctl_d_r) && (ctl_d_r == ctl_e_r);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside answer cycle");
    a_status_upper: assert property (reg_rd && reg_addr == `SSC_OFS_FIFO_STATUS
        |=> reg_rdata[31:5] == 27'h0)
        else $error("status upper bits set");
    a_data_upper: assert property (reg_rd && reg_addr == `SSC_OFS_FIFO_DATA
        |=> reg_rdata[31:16] == 16'h0)
        else $error("data read upper bits set");
    a_master_drive: assert property (calm && ctl_r[1] && !ctl_r[2]
        |-> !link_clk_oe_b && !sel_oe_b && !serial_data_out_oe_b)
        else $error("master not driving pins");
    a_off_quiet: assert property (calm && !ctl_r[1]
        |-> link_clk_oe_b && sel_oe_b && serial_data_out_oe_b)
        else $error("disabled port drives a pin");
    a_slave_listen: assert property (calm && ctl_r[2] |-> link_clk_oe_b && sel_oe_b)
        else $error("slave drives clock or select");
    a_sod_gates: assert property (calm && ctl_r[2] && ctl_r[3] |-> serial_data_out_oe_b)
        else $error("slave data driven while disabled");
    a_clk_half: assert property ($rose(link_clk_out) |-> link_clk_out[*8] ##1 !link_clk_out)
        else $error("link clock half period wrong");
    a_clk_framed: assert property (link_clk_out |-> !sel_out_b)
        else $error("link clock outside frame");
    a_reset_vals: assert property (disable iff (1'b0) !rst_b |=> reg_rdata == 32'h0
        && !irq && !link_clk_out && sel_out_b && link_clk_oe_b)
        else $error("outputs not quiet in reset");
    c_master_frame: cover property ($rose(sel_out_b));
    c_irq: cover property ($rose(irq));
    c_slave: cover property (calm && ctl_r[2] && !serial_data_out_oe_b);
endmodule
bind ssc_top ssc_top_chk u_chk (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq(irq), .link_clk_out(link_clk_out), .link_clk_oe_b(link_clk_oe_b),
    .sel_out_b(sel_out_b), .sel_oe_b(sel_oe_b), .serial_data_out_oe_b(serial_data_out_oe_b));
`default_nettype wire

// >>> tb/ssc_peer.sv
// serial master peer, mode 0, msb first, clock still between frames
`timescale 1ns/100ps
`default_nettype none
module ssc_peer (
    output logic peer_clk,
    output logic peer_sel_b,
    output logic peer_mosi,
    input wire logic peer_miso
);
    initial begin
        peer_clk = 1'b0; // idle low
        peer_sel_b = 1'b1; // not selected
        peer_mosi = 1'b1; // idle line level
    end
    // one 8-bit frame, half period 62.5 ns
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        peer_sel_b = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            peer_mosi = tx[i]; // set before rising edge
            #62.5 peer_clk = 1'b1;
            rx[i] = peer_miso; // sample on rising edge
            #62.5 peer_clk = 1'b0;
        end
        #62.5 peer_sel_b = 1'b1;
        peer_mosi = ~peer_mosi; // released line shows no stale bit
        #125;
    endtask
endmodule
`default_nettype wire

// >>> tb/sync_serial_ctrl_status_data_tb.sv
// register-level bench of the serial port
`timescale 1ns/100ps
`default_nettype none
`include "ssc_cfg.svh"
module sync_serial_ctrl_status_data_tb;
    import ssc_pkg::*;
    logic core_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, got;
    logic irq, lco, lco_b, so_b, sel_oe_b, sdo, sdo_oe_b, pclk, psel_b, pmosi;
    logic [7:0] prx;
    int err_total = 0, total_checks = 0;
    logic [3:0] sz [4] = '{4'h3, 4'h7, 4'hf, 4'h0}; // frame size codes, last one reserved
    logic [15:0] ex [4] = '{16'h0005, 16'h00f5, 16'hfff5, 16'h0005}; // words back per code
    always #4 core_clk = ~core_clk;
    ssc_top u_dut (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .irq(irq), .link_clk_out(lco), .link_clk_oe_b(lco_b),
        .link_clk_in(lco_b ? pclk : lco), .sel_out_b(so_b), .sel_oe_b(sel_oe_b),
        .sel_in_b(sel_oe_b ? psel_b : so_b), .serial_data_out(sdo),
        .serial_data_out_oe_b(sdo_oe_b), .serial_data_in(pmosi));
    // pull-up on the slave data line when released
    ssc_peer u_peer (.peer_clk(pclk), .peer_sel_b(psel_b), .peer_mosi(pmosi),
        .peer_miso(sdo_oe_b ? 1'b1 : sdo));
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        rd(a, got);
        chk(got, exp);
    endtask
    // wait for a master frame to close, bounded
    task automatic wait_frame();
        int n;
        n = 0;
        while (so_b !== 1'b0 && n < 50) begin
            @(posedge core_clk);
            n++;
        end
        while (so_b !== 1'b1 && n < 400) begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 400) chk(32'h1, 32'h0);
        repeat (4) @(posedge core_clk);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        #400000;
        err_total++;
        tally_and_finish();
    end
    initial begin
        repeat (8) @(posedge core_clk);
        rst_b <= 1'b1;
        rchk(`SSC_OFS_FIFO_STATUS, 32'h03);
        rchk(`SSC_OFS_CTRL_TWO, 32'h0);
        $display("test reset done");
        // loopback frames at four size codes, upper bits dropped, output gate ignored
        wr(`SSC_OFS_CTRL_TWO, 32'hb);
        for (int i = 0; i < 4; i++) begin
            wr(`SSC_OFS_FRAME_CFG, {28'h0, sz[i]});
            wr(`SSC_OFS_FIFO_DATA, 32'h5a5a_fff5);
            repeat (3) @(posedge core_clk);
            rchk(`SSC_OFS_FIFO_STATUS, 32'h13);
            wait_frame();
            rchk(`SSC_OFS_FIFO_STATUS, 32'h07);
            rchk(`SSC_OFS_FIFO_DATA, {16'h0, ex[i]});
            rchk(`SSC_OFS_FIFO_STATUS, 32'h03);
        end
        $display("test loopback lengths done");
        // interrupt: sticky, masked, then cleared by writing ones
        chk({31'h0, irq}, 32'h0);
        rchk(`SSC_OFS_IRQ_STATUS, 32'h5);
        wr(`SSC_OFS_IRQ_MASK, 32'h1);
        @(posedge core_clk);
        chk({31'h0, irq}, 32'h1);
        wr(`SSC_OFS_IRQ_STATUS, 32'h7);
        @(posedge core_clk);
        chk({31'h0, irq}, 32'h0);
        rchk(`SSC_OFS_IRQ_STATUS, 32'h0);
        rchk(8'h3c, 32'h0);
        $display("test interrupt done");
        // fill the transmit fifo while disabled, then drain into a full receive fifo
        wr(`SSC_OFS_FRAME_CFG, 32'h7);
        wr(`SSC_OFS_CTRL_TWO, 32'h1);
        for (int i = 0; i < 9; i++) wr(`SSC_OFS_FIFO_DATA, 32'h40 + i);
        rchk(`SSC_OFS_FIFO_STATUS, 32'h10);
        wr(`SSC_OFS_CTRL_TWO, 32'h3);
        for (int i = 0; i < 8; i++) wait_frame();
        rchk(`SSC_OFS_FIFO_STATUS, 32'h0f);
        for (int i = 0; i < 8; i++) rchk(`SSC_OFS_FIFO_DATA, 32'h40 + i);
        rchk(`SSC_OFS_FIFO_DATA, 32'h0);
        rchk(`SSC_OFS_FIFO_STATUS, 32'h03);
        $display("test fifo fill and drain done");
        // slave: role, then data, then enable last
        wr(`SSC_OFS_CTRL_TWO, 32'h4);
        wr(`SSC_OFS_FIFO_DATA, 32'h5a);
        wr(`SSC_OFS_CTRL_TWO, 32'h6);
        u_peer.xfer(8'hc3, prx);
        chk({24'h0, prx}, 32'h5a);
        rchk(`SSC_OFS_FIFO_DATA, 32'hc3);
        wr(`SSC_OFS_CTRL_TWO, 32'hc);
        wr(`SSC_OFS_FIFO_DATA, 32'h00);
        wr(`SSC_OFS_CTRL_TWO, 32'he);
        u_peer.xfer(8'h3c, prx);
        chk({24'h0, prx}, 32'hff);
        rchk(`SSC_OFS_FIFO_DATA, 32'h3c);
        $display("test slave done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
